// File: dct_channel.sv
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "dct_params.svh"

// Summary of operation
// - bit 15 reads 1 while a fetched word awaits its store in dummy-write mode
// - bits 14..8 pick the trigger source; all zeros selects none
// - serial peripheral and timer events map to fixed trigger codes
// - other channels' completion events can trigger; channel 0 highest code
// - bus collision and pin change have own codes; unlisted codes trigger nothing
// - bit 7 set on access above upper limit or top of data RAM
// - bit 6 set on access below lower limit yet above register space
// - limit check happens with or after the access, never before
// - enabled: done reads 1 after completed session, 0 while unfinished
// - disabled: done reads 1 if last session completed, 0 if aborted
// - bit 4 set when the counter reaches halfway toward zero
// - bit 3 set when a trigger arrives while previous operation still runs
// - halfway enable set: interrupt at halfway and at completion
// - halfway enable clear: interrupt only at completion
// - software setting flags never raises the channel interrupt
// - dummy-write mode writes the source location for every destination write
// - channel starts transfers only while its enable bit is 1; a begun store still does its dummy write
module dct_channel (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [127:0] trigger_events_in,
    output logic mem_req_out,
    output logic mem_write_out,
    output logic [15:0] mem_addr_out,
    output logic [15:0] mem_wdata_out,
    input wire logic [15:0] mem_rdata_in,
    output logic channel_irq_out
);
    dct_pkg::dct_state_t state_reg;
    logic [15:0] ctrl_reg;
    logic [15:0] source_pointer_reg;
    logic [15:0] destination_pointer_reg;
    logic [15:0] transaction_counter_reg;
    logic [15:0] count_left_reg;
    logic [15:0] upper_address_limit_reg;
    logic [15:0] lower_address_limit_reg;
    logic [15:0] buffer_reg;
    logic [6:0] trigger_select_reg;
    logic buffered_write_pending_reg;
    logic upper_limit_violation_flag_reg;
    logic lower_limit_violation_flag_reg;
    logic session_complete_flag_reg;
    logic halfway_flag_reg;
    logic retrigger_overrun_flag_reg;
    logic halfway_interrupt_enable_reg;
    logic enable_prev_reg;

    logic wr_en;
    logic rd_setup;
    logic wr_int;
    logic trig_fire;
    logic access_now;
    logic [15:0] access_addr;
    logic above_limit;
    logic below_limit;
    logic [15:0] count_next;
    logic last_word;
    logic at_half;
    logic channel_enable;
    logic dummy_write_mode;
    logic [15:0] int_view;
    logic [31:0] rdata_next;
    logic addr_ok;

    function automatic logic dct_mapped(input logic [11:0] a);
        case (a)
            `DCT_OFS_CTRL, `DCT_OFS_INT, `DCT_OFS_SRC, `DCT_OFS_DST,
            `DCT_OFS_CNT, `DCT_OFS_UPPER, `DCT_OFS_LOWER: dct_mapped = 1'b1;
            default: dct_mapped = 1'b0;
        endcase
    endfunction

    dct_trig_decode u_trig_decode (
        .select_in(trigger_select_reg),
        .events_in(trigger_events_in),
        .fire_out(trig_fire)
    );

    assign channel_enable = ctrl_reg[`DCT_CTRL_ENABLE];
    assign dummy_write_mode = ctrl_reg[`DCT_CTRL_DUMMY];
    assign addr_ok = dct_mapped(paddr_in);
    assign wr_en = psel_in && penable_in && pready_out && pwrite_in && addr_ok;
    assign rd_setup = psel_in && !penable_in && !pready_out;
    assign wr_int = wr_en && paddr_in == `DCT_OFS_INT;

    // access issued this cycle and the address it uses
    assign access_now = state_reg != dct_pkg::DCT_IDLE;
    assign access_addr = (state_reg == dct_pkg::DCT_WRITE) ? destination_pointer_reg
                                                           : source_pointer_reg;
    assign above_limit = access_addr > upper_address_limit_reg ||
                         access_addr == `DCT_RAM_TOP;
    assign below_limit = access_addr < lower_address_limit_reg &&
                         access_addr > `DCT_SFR_END;
    assign count_next = count_left_reg - 16'h0001;
    assign last_word = count_next == `DCT_RST_WORD;
    assign at_half = count_next == (transaction_counter_reg >> 1);

    always_comb begin
        int_view = `DCT_RST_WORD;
        int_view[`DCT_INT_PENDING] = buffered_write_pending_reg;
        int_view[`DCT_INT_SEL_HI:`DCT_INT_SEL_LO] = trigger_select_reg;
        int_view[`DCT_INT_UPPER] = upper_limit_violation_flag_reg;
        int_view[`DCT_INT_LOWER] = lower_limit_violation_flag_reg;
        int_view[`DCT_INT_DONE] = session_complete_flag_reg;
        int_view[`DCT_INT_HALF] = halfway_flag_reg;
        int_view[`DCT_INT_OVRUN] = retrigger_overrun_flag_reg;
        int_view[`DCT_INT_HALFWAY_INTERRUPT_ENABLE] = halfway_interrupt_enable_reg;
    end

    always_comb begin
        rdata_next = 32'h00000000;
        case (paddr_in)
            `DCT_OFS_CTRL: rdata_next = {16'h0000, ctrl_reg};
            `DCT_OFS_INT: rdata_next = {16'h0000, int_view};
            `DCT_OFS_SRC: rdata_next = {16'h0000, source_pointer_reg};
            `DCT_OFS_DST: rdata_next = {16'h0000, destination_pointer_reg};
            `DCT_OFS_CNT: rdata_next = {16'h0000, transaction_counter_reg};
            `DCT_OFS_UPPER: rdata_next = {16'h0000, upper_address_limit_reg};
            `DCT_OFS_LOWER: rdata_next = {16'h0000, lower_address_limit_reg};
            default: rdata_next = 32'h00000000;
        endcase
    end

    // apb answer: pready one cycle after setup, data latched with it
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else begin
            pready_out <= rd_setup;
            pslverr_out <= rd_setup && !addr_ok;
            if (rd_setup) begin
                prdata_out <= rdata_next;
            end
        end
    end

    // plain software registers
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            upper_address_limit_reg <= `DCT_RST_WORD;
            lower_address_limit_reg <= `DCT_RST_WORD;
            transaction_counter_reg <= `DCT_RST_WORD;
            trigger_select_reg <= `DCT_RST_SEL;
            halfway_interrupt_enable_reg <= 1'b0;
        end else if (wr_en) begin
            case (paddr_in)
                `DCT_OFS_UPPER: upper_address_limit_reg <= pwdata_in[15:0];
                `DCT_OFS_LOWER: lower_address_limit_reg <= pwdata_in[15:0];
                `DCT_OFS_CNT: transaction_counter_reg <= pwdata_in[15:0];
                `DCT_OFS_INT: begin
                    trigger_select_reg <= pwdata_in[`DCT_INT_SEL_HI:`DCT_INT_SEL_LO];
                    halfway_interrupt_enable_reg <= pwdata_in[`DCT_INT_HALFWAY_INTERRUPT_ENABLE];
                end
                default: begin
                end
            endcase
        end
    end

    // control: software writes, hardware clears enable at session end
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= `DCT_RST_WORD;
            enable_prev_reg <= 1'b0;
        end else begin
            enable_prev_reg <= channel_enable;
            if (wr_en && paddr_in == `DCT_OFS_CTRL) begin
                ctrl_reg <= `DCT_RST_WORD;
                ctrl_reg[`DCT_CTRL_ENABLE] <= pwdata_in[`DCT_CTRL_ENABLE];
                ctrl_reg[`DCT_CTRL_DUMMY] <= pwdata_in[`DCT_CTRL_DUMMY];
            end else if (state_reg == dct_pkg::DCT_WRITE && !dummy_write_mode && last_word) begin
                ctrl_reg[`DCT_CTRL_ENABLE] <= 1'b0;
            end else if (state_reg == dct_pkg::DCT_DUMMY && last_word) begin
                ctrl_reg[`DCT_CTRL_ENABLE] <= 1'b0;
            end
        end
    end

    // transfer engine: fetch, store, optional dummy store
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_reg <= dct_pkg::DCT_IDLE;
            buffer_reg <= `DCT_RST_WORD;
            count_left_reg <= `DCT_RST_WORD;
            source_pointer_reg <= `DCT_RST_WORD;
            destination_pointer_reg <= `DCT_RST_WORD;
        end else begin
            if (wr_en && paddr_in == `DCT_OFS_SRC) begin
                source_pointer_reg <= pwdata_in[15:0];
            end
            if (wr_en && paddr_in == `DCT_OFS_DST) begin
                destination_pointer_reg <= pwdata_in[15:0];
            end
            if (channel_enable && !enable_prev_reg) begin
                count_left_reg <= transaction_counter_reg;
            end
            case (state_reg)
                dct_pkg::DCT_IDLE: begin
                    if (channel_enable && enable_prev_reg && trig_fire) begin
                        state_reg <= dct_pkg::DCT_READ;
                    end
                end
                dct_pkg::DCT_READ: begin
                    buffer_reg <= mem_rdata_in;
                    state_reg <= channel_enable ? dct_pkg::DCT_WRITE : dct_pkg::DCT_IDLE;
                end
                dct_pkg::DCT_WRITE: begin
                    if (dummy_write_mode) begin
                        state_reg <= dct_pkg::DCT_DUMMY;
                    end else begin
                        state_reg <= dct_pkg::DCT_IDLE;
                        count_left_reg <= count_next;
                    end
                end
                dct_pkg::DCT_DUMMY: begin
                    state_reg <= dct_pkg::DCT_IDLE;
                    count_left_reg <= count_next;
                end
                default: state_reg <= dct_pkg::DCT_IDLE;
            endcase
        end
    end

    // memory strobes, registered from the engine state
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            mem_req_out <= 1'b0;
            mem_write_out <= 1'b0;
            mem_addr_out <= `DCT_RST_WORD;
            mem_wdata_out <= `DCT_RST_WORD;
        end else begin
            mem_req_out <= access_now;
            mem_write_out <= state_reg == dct_pkg::DCT_WRITE || state_reg == dct_pkg::DCT_DUMMY;
            mem_addr_out <= access_addr;
            mem_wdata_out <= (state_reg == dct_pkg::DCT_READ) ? mem_rdata_in : buffer_reg;
        end
    end

    // status flags: hardware sets win over software clears
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            buffered_write_pending_reg <= 1'b0;
            upper_limit_violation_flag_reg <= 1'b0;
            lower_limit_violation_flag_reg <= 1'b0;
            session_complete_flag_reg <= 1'b0;
            halfway_flag_reg <= 1'b0;
            retrigger_overrun_flag_reg <= 1'b0;
        end else begin
            if (state_reg == dct_pkg::DCT_READ && dummy_write_mode) begin
                buffered_write_pending_reg <= 1'b1;
            end else if (state_reg == dct_pkg::DCT_DUMMY || !channel_enable) begin
                buffered_write_pending_reg <= 1'b0;
            end
            upper_limit_violation_flag_reg <= (access_now && above_limit) ||
                (wr_int ? pwdata_in[`DCT_INT_UPPER] : upper_limit_violation_flag_reg);
            lower_limit_violation_flag_reg <= (access_now && below_limit) ||
                (wr_int ? pwdata_in[`DCT_INT_LOWER] : lower_limit_violation_flag_reg);
            if (channel_enable && !enable_prev_reg) begin
                session_complete_flag_reg <= 1'b0;
            end else begin
                session_complete_flag_reg <= (access_now && count_done_now()) ||
                    (wr_int ? pwdata_in[`DCT_INT_DONE] : session_complete_flag_reg);
            end
            halfway_flag_reg <= (count_done_step() && at_half) ||
                (wr_int ? pwdata_in[`DCT_INT_HALF] : halfway_flag_reg);
            retrigger_overrun_flag_reg <= (access_now && trig_fire) ||
                (wr_int ? pwdata_in[`DCT_INT_OVRUN] : retrigger_overrun_flag_reg);
        end
    end

    // interrupt pulse only from hardware events
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            channel_irq_out <= 1'b0;
        end else begin
            channel_irq_out <= count_done_now() ||
                (halfway_interrupt_enable_reg && count_done_step() && at_half);
        end
    end

    // one word finished this cycle
    function automatic logic count_done_step();
        count_done_step = (state_reg == dct_pkg::DCT_WRITE && !dummy_write_mode) ||
                          state_reg == dct_pkg::DCT_DUMMY;
    endfunction

    function automatic logic count_done_now();
        count_done_now = count_done_step() && last_word;
    endfunction
endmodule

// File: dct_channel_monitor.sv
`timescale 1ns/1ps
`include "dct_params.svh"
module dct_channel_monitor (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [11:0] paddr_in,
    input wire logic [127:0] trigger_events_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic mem_req_out,
    input wire logic mem_write_out,
    input wire logic channel_irq_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence rd_s;
        mem_req_out && !mem_write_out;
    endsequence
    sequence wr_s;
        mem_req_out && mem_write_out;
    endsequence
    apb_answer_a: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    err_map_a: assert property (pslverr_out |-> pready_out && !(paddr_in inside {`DCT_OFS_CTRL,
        `DCT_OFS_INT, `DCT_OFS_SRC, `DCT_OFS_DST, `DCT_OFS_CNT, `DCT_OFS_UPPER, `DCT_OFS_LOWER}))
        else $error("error on mapped address");
    upper_zero_a: assert property (pready_out |-> prdata_out[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    write_follows_a: assert property (rd_s |=> wr_s)
        else $error("read not followed by write");
    read_cause_a: assert property (rd_s |-> $past(|trigger_events_in, 2) ||
        $past(|trigger_events_in, 3))
        else $error("read without trigger");
    irq_cause_a: assert property (channel_irq_out |->
        mem_req_out || $past(mem_req_out) || $past(mem_req_out, 2) || $past(mem_req_out, 3))
        else $error("interrupt without transfer");
    irq_pulse_a: assert property (channel_irq_out |=> !channel_irq_out)
        else $error("interrupt longer than one cycle");
    reset_quiet_a: assert property (disable iff (1'b0) !rst_n_in |=>
        !mem_req_out && !channel_irq_out && !pready_out)
        else $error("outputs active after reset");
endmodule

// File: dct_channel_tb.sv
`timescale 1ns/1ps
`include "dct_params.svh"
module dct_channel_tb;
    localparam logic [15:0] RW = 16'h5A3C;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [127:0] ev = 128'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, mreq, mwr, irq, err;
    logic [15:0] maddr, mwdata, mrdata, last_addr, last_data;
    logic [7:0] wr_cnt;
    int bad_count = 0;
    int total_checks = 0;
    int irq_cnt = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    dct_channel u_dct_channel (.core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .trigger_events_in(ev), .mem_req_out(mreq), .mem_write_out(mwr),
        .mem_addr_out(maddr), .mem_wdata_out(mwdata), .mem_rdata_in(mrdata),
        .channel_irq_out(irq));
    dct_mem_model #(.READ_WORD(RW)) u_dct_mem_model (.core_clk_in(clk), .rst_n_in(rst_n),
        .mem_req_in(mreq), .mem_write_in(mwr), .mem_addr_in(maddr), .mem_wdata_in(mwdata),
        .mem_rdata_out(mrdata), .last_addr_out(last_addr), .last_data_out(last_data),
        .wr_count_out(wr_cnt));
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            bad_count++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rd_int(input logic [15:0] exp);
        apb(1'b0, `DCT_OFS_INT, 16'h0000);
        check(rd, {16'h0000, exp});
    endtask
    task automatic pulse(input logic [127:0] m, input int len);
        @(posedge clk);
        ev <= m;
        repeat (len) @(posedge clk);
        ev <= 128'h0;
        repeat (8) @(posedge clk);
    endtask
    task automatic setup(input logic [15:0] s, d, c, iv, ct);
        apb(1'b1, `DCT_OFS_SRC, s);
        apb(1'b1, `DCT_OFS_DST, d);
        apb(1'b1, `DCT_OFS_CNT, c);
        apb(1'b1, `DCT_OFS_INT, iv);
        apb(1'b1, `DCT_OFS_CTRL, ct);
    endtask
    task automatic s_reset();
        rd_int(16'h0000);
        apb(1'b0, 12'h01C, 16'h0000);
        check({rd[0], err}, 2'b01);
        apb(1'b1, `DCT_OFS_UPPER, 16'h8000);
        apb(1'b1, `DCT_OFS_LOWER, 16'h1000);
    endtask
    task automatic s_codes();
        logic [6:0] codes [8];
        int i, b;
        codes = '{`DCT_TRIG_UART1_RX, `DCT_TRIG_SPI1_RX, `DCT_TRIG_I2C2_COLL, `DCT_TRIG_TMR1,
            `DCT_TRIG_CH0_DONE, `DCT_TRIG_CH5_DONE, `DCT_TRIG_I2C1_COLL, `DCT_TRIG_PIN_CHANGE};
        for (i = 0; i < 8; i++) begin
            b = irq_cnt;
            setup(16'h1000, 16'h2000, 16'h0001, {1'b0, codes[i], 8'h00}, 16'h0001);
            pulse(128'h1 << codes[i], 1);
            check(irq_cnt - b, 32'h1);
            // a single-word session also meets the halfway point on its last word
            rd_int({1'b0, codes[i], 8'h30});
            check({last_addr, last_data}, {16'h2000, RW});
            apb(1'b1, `DCT_OFS_INT, 16'h0000);
        end
    endtask
    task automatic s_refuse();
        logic [7:0] b;
        b = wr_cnt;
        setup(16'h1000, 16'h2000, 16'h0001, 16'h0000, 16'h0001);
        pulse({128{1'b1}}, 1);
        check(wr_cnt, b);
        apb(1'b1, `DCT_OFS_INT, 16'h0100);
        pulse(128'h2, 1);
        check(wr_cnt, b);
        setup(16'h1000, 16'h2000, 16'h0001, 16'h4500, 16'h0000);
        pulse(128'h1 << 7'h45, 1);
        check(wr_cnt, b);
    endtask
    task automatic s_half(input logic en);
        int b;
        b = irq_cnt;
        setup(16'h1000, 16'h2000, 16'h0002, {8'h45, 7'h00, en}, 16'h0001);
        pulse(128'h1 << 7'h45, 1);
        rd_int({8'h45, 7'h08, en});
        pulse(128'h1 << 7'h45, 1);
        check(irq_cnt - b, en ? 32'h2 : 32'h1);
        rd_int({8'h45, 7'h18, en});
        apb(1'b1, `DCT_OFS_INT, 16'h0000);
    endtask
    task automatic s_overrun();
        setup(16'h1000, 16'h2000, 16'h0004, 16'h4500, 16'h0001);
        pulse(128'h1 << 7'h45, 2);
        rd_int(16'h4508);
        setup(16'h1000, 16'h2000, 16'h0001, 16'h0000, 16'h0000);
    endtask
    task automatic s_limits();
        setup(16'h1000, 16'hFFFF, 16'h0001, 16'h4500, 16'h0001);
        pulse(128'h1 << 7'h45, 1);
        check(last_addr, 16'hFFFF);
        rd_int(16'h45B0);
        apb(1'b1, `DCT_OFS_SRC, 16'h0900);
        apb(1'b1, `DCT_OFS_DST, 16'h2000);
        apb(1'b1, `DCT_OFS_CNT, 16'h0001);
        apb(1'b1, `DCT_OFS_CTRL, 16'h0001);
        pulse(128'h1 << 7'h45, 1);
        rd_int(16'h45F0);
        apb(1'b1, `DCT_OFS_INT, 16'h0000);
    endtask
    task automatic s_soft();
        int b;
        b = irq_cnt;
        apb(1'b1, `DCT_OFS_INT, 16'h00FE);
        repeat (6) @(posedge clk);
        check(irq_cnt - b, 32'h0);
        rd_int(16'h00F8);
        apb(1'b1, `DCT_OFS_INT, 16'h0000);
        rd_int(16'h0000);
    endtask
    task automatic s_dummy();
        logic [7:0] b;
        b = wr_cnt;
        setup(16'h1200, 16'h1300, 16'h0001, 16'h4500, 16'h0401);
        pulse(128'h1 << 7'h45, 1);
        check(wr_cnt - b, 8'h02);
        check({last_addr, last_data}, {16'h1200, RW});
        rd_int(16'h4530);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        s_reset();
        s_codes();
        s_refuse();
        s_half(1'b1);
        s_half(1'b0);
        s_overrun();
        s_limits();
        s_soft();
        s_dummy();
        print_verdict();
    end
endmodule
bind dct_channel dct_channel_monitor u_dct_channel_monitor (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in),
    .trigger_events_in(trigger_events_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .mem_req_out(mem_req_out), .mem_write_out(mem_write_out),
    .channel_irq_out(channel_irq_out));

// File: dct_mem_model.sv
`timescale 1ns/1ps
module dct_mem_model #(
    parameter logic [15:0] READ_WORD = 16'h5A3C
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic mem_req_in,
    input wire logic mem_write_in,
    input wire logic [15:0] mem_addr_in,
    input wire logic [15:0] mem_wdata_in,
    output logic [15:0] mem_rdata_out,
    output logic [15:0] last_addr_out,
    output logic [15:0] last_data_out,
    output logic [7:0] wr_count_out
);
    // combinational memory, one stored word seen everywhere
    assign mem_rdata_out = READ_WORD;
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            wr_count_out <= 8'h00;
            last_addr_out <= 16'h0000;
            last_data_out <= 16'h0000;
        end else if (mem_req_in && mem_write_in) begin
            wr_count_out <= wr_count_out + 8'h01;
            last_addr_out <= mem_addr_in;
            last_data_out <= mem_wdata_in;
        end
    end
endmodule

// File: dct_params.svh
`ifndef DCT_PARAMS_SVH
`define DCT_PARAMS_SVH

// register byte offsets
`define DCT_OFS_CTRL 12'h000
`define DCT_OFS_INT 12'h004
`define DCT_OFS_SRC 12'h008
`define DCT_OFS_DST 12'h00C
`define DCT_OFS_CNT 12'h010
`define DCT_OFS_UPPER 12'h014
`define DCT_OFS_LOWER 12'h018

// control register fields
`define DCT_CTRL_ENABLE 0
`define DCT_CTRL_DUMMY 10

// interrupt register fields
`define DCT_INT_PENDING 15
`define DCT_INT_SEL_HI 14
`define DCT_INT_SEL_LO 8
`define DCT_INT_UPPER 7
`define DCT_INT_LOWER 6
`define DCT_INT_DONE 5
`define DCT_INT_HALF 4
`define DCT_INT_OVRUN 3
`define DCT_INT_HALFWAY_INTERRUPT_ENABLE 0
`define DCT_INT_WMASK 16'h7FF9

// reset values
`define DCT_RST_WORD 16'h0000
`define DCT_RST_SEL 7'h00

// address map
`define DCT_SFR_END 16'h07FF
`define DCT_RAM_TOP 16'hFFFF

// trigger codes
`define DCT_TRIG_OFF 7'h00
`define DCT_TRIG_UART1_RX 7'h45
`define DCT_TRIG_SPI1_RX 7'h26
`define DCT_TRIG_I2C2_COLL 7'h31
`define DCT_TRIG_I2C1_COLL 7'h34
`define DCT_TRIG_TMR1 7'h63
`define DCT_TRIG_CH0_DONE 7'h50
`define DCT_TRIG_CH5_DONE 7'h4B
`define DCT_TRIG_PIN_CHANGE 7'h6D

`endif

// File: dct_pkg.sv
package dct_pkg;
    typedef enum logic [1:0] {
        DCT_IDLE,
        DCT_READ,
        DCT_WRITE,
        DCT_DUMMY
    } dct_state_t;
endpackage

// File: dct_trig_decode.sv
`timescale 1ns/1ps
`include "dct_params.svh"

module dct_trig_decode (
    input wire logic [6:0] select_in,
    input wire logic [127:0] events_in,
    output logic fire_out
);
    // codes absent from the source table start nothing
    function automatic logic dct_code_listed(input logic [6:0] code);
        case (code) inside
            [7'h09:7'h10], [7'h14:7'h16], [7'h1A:7'h1C], [7'h20:7'h28],
            [7'h2F:7'h34], [7'h41:7'h46], [7'h4B:7'h51], [7'h53:7'h55],
            7'h5B, 7'h5C, 7'h5E, [7'h61:7'h63], [7'h66:7'h6D]: dct_code_listed = 1'b1;
            default: dct_code_listed = 1'b0;
        endcase
    endfunction

    always_comb begin
        fire_out = 1'b0;
        if (select_in != `DCT_TRIG_OFF && dct_code_listed(select_in)) begin
            fire_out = events_in[select_in];
        end
    end
endmodule
